// [design/acs_fuse_load.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_fuse_load (
	input wire logic clk, // system clock
	input wire logic sys_rst, // hardware reset, sync, high
	output logic ready // fuses loaded and applied
);

	acs_pkg::acs_fuse_state_type state_r;
	logic [9:0] cnt_r;

	//////////////////////////////////////////////////////////////////////
	// fuse load timer; only hardware reset restarts it, not soft reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= acs_pkg::FUSE_LOADING;
			cnt_r <= 10'h000;
			ready <= 1'b0;
		end else begin
			case (state_r)
				acs_pkg::FUSE_LOADING: begin
					ready <= 1'b0;
					if (cnt_r == 10'(`ACS_FUSE_CYC - 1)) begin
						state_r <= acs_pkg::FUSE_DONE;
						ready <= 1'b1;
					end else begin
						cnt_r <= cnt_r + 10'h001;
					end
				end
				acs_pkg::FUSE_DONE: begin
					ready <= 1'b1;
				end
				default: begin
					state_r <= acs_pkg::FUSE_LOADING;
					ready <= 1'b0;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// [design/acs_ovr_stretch.sv]
`timescale 1ns/1ps
`default_nettype none

module acs_ovr_stretch (
	input wire logic clk, // system clock
	input wire logic rst, // hardware or soft reset
	input wire logic ovrIn, // raw overrange, one per cycle
	input wire logic sticky, // hold mode
	input wire logic clrCode, // clear code written, one-cycle pulse
	input wire logic [7:0] len, // stretch length N
	output logic ovrOut // stretched or held indication
);

	logic [7:0] cnt_r;

	//////////////////////////////////////////////////////////////////////
	// a new event reloads the count, so output drops N+1 after the last
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 8'h00;
			ovrOut <= 1'b0;
		end else if (ovrIn) begin
			cnt_r <= len;
			ovrOut <= 1'b1; // set wins over clear code
		end else if (sticky) begin
			cnt_r <= 8'h00;
			if (clrCode) begin
				ovrOut <= 1'b0;
			end
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end else begin
			ovrOut <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [design/acs_regs.sv]
// Functional notes
// - config ready reads 0 until fuses load
// - reset bit restores defaults, then self-clears
// - power-down bit powers the whole device down
// - selected gpio pin also requests power down
// - clear bit resets refsync detect flag
// - hold mode keeps overrange until cleared
// - clear code 2 in bits 2:1 clears
// - stretch length N gives N+1 cycle pulse
// - channel swap resets 1; 0 exchanges channels
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_regs (
	input wire logic clk, // system clock, 200 MHz
	input wire logic sys_rst, // hardware reset, sync, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [13:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic ovrIn, // raw overrange event
	input wire logic refsyncIn, // refsync detected, pulse
	input wire logic gpioPin, // general-purpose pin level
	input wire logic [15:0] chAIn, // channel A sample
	input wire logic [15:0] chBIn, // channel B sample
	output logic [15:0] chAOut, // channel A after swap
	output logic [15:0] chBOut, // channel B after swap
	output logic ovrOut, // overrange indication
	output logic powerDown, // global power down
	output logic cfgReady, // configuration ready
	output logic [1:0] termCtrl, // input termination, B:A
	output logic lvdsTerm, // lvds termination select
	output logic lvdsHalfSwing, // lvds reduced swing
	output logic irq // level interrupt
);

	//////////////////////////////////////////////////////////////////////
	// declarations
	logic regRst;
	logic ack_r;
	logic wrEn;
	logic [11:0] idx;
	logic swRst_r;
	logic gpd_r;
	logic refClr_r;
	logic refFlag_r;
	logic [1:0] term_r;
	logic [2:0] ovrCtrl_r;
	logic [7:0] ovrLen_r;
	logic lvdsTerm_r;
	logic halfSwing_r;
	logic chanSwap_r;
	logic [4:0] gpioCfg_r;
	logic [2:0] intStat_r;
	logic [2:0] intMask_r;
	logic [2:0] intSet;
	logic ovrClrPulse;
	logic ovrStretched;
	logic ovrPrev_r;
	logic fuseReady;
	logic cfgPrev_r;
	logic [31:0] rdData;
	// a literal cannot be bit-selected, so the link reset word gets a name
	localparam logic [7:0] LinkResetVal = `ACS_LINK_RESET;

	// write hit on one register index
	function automatic logic wrHit(input logic en, input logic [11:0] a, input logic [11:0] r);
		wrHit = en && (a == r);
	endfunction

	//////////////////////////////////////////////////////////////////////
	// bus decode; the write lands on the edge that the master sees ack
	assign idx = wb_adr_i[13:2];
	assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

	// soft reset pulse acts like a reset for every register except fuses, bus ack and read data, and cfgPrev_r
	assign regRst = sys_rst || swRst_r;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// software reset bit: one-cycle pulse, self-clears without software
	always_ff @(posedge clk) begin
		if (regRst) begin
			swRst_r <= 1'b0;
		end else begin
			swRst_r <= wrHit(wrEn, idx, `ACS_IDX_SW_RST) && wb_dat_i[`ACS_BIT_SW_RST];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// power-down, termination and gpio function controls
	always_ff @(posedge clk) begin
		if (regRst) begin
			gpd_r <= 1'b0;
			term_r <= 2'h0;
			gpioCfg_r <= 5'h00;
		end else begin
			if (wrHit(wrEn, idx, `ACS_IDX_GPD)) begin
				gpd_r <= wb_dat_i[`ACS_BIT_GPD];
			end
			if (wrHit(wrEn, idx, `ACS_IDX_TERM)) begin
				term_r <= wb_dat_i[1:0];
			end
			if (wrHit(wrEn, idx, `ACS_IDX_GPIO_CFG)) begin
				gpioCfg_r <= wb_dat_i[4:0];
			end
		end
	end

	// power down from the bit, or from the pin when so selected
	always_ff @(posedge clk) begin
		if (regRst) begin
			powerDown <= 1'b0;
		end else begin
			powerDown <= gpd_r
				|| (gpioCfg_r == `ACS_GPIO_PDN_CODE && gpioPin);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// refsync detect: clear bit is a level, a new detection wins over it
	always_ff @(posedge clk) begin
		if (regRst) begin
			refClr_r <= 1'b0;
		end else if (wrHit(wrEn, idx, `ACS_IDX_REFCLR)) begin
			refClr_r <= wb_dat_i[`ACS_BIT_REFCLR];
		end
	end

	always_ff @(posedge clk) begin
		if (regRst) begin
			refFlag_r <= 1'b0;
		end else if (refsyncIn) begin
			refFlag_r <= 1'b1;
		end else if (refClr_r) begin
			refFlag_r <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// overrange control; clear code only acts as a write event
	always_ff @(posedge clk) begin
		if (regRst) begin
			ovrCtrl_r <= 3'h0;
			ovrLen_r <= `ACS_OVR_LEN_RESET;
		end else begin
			if (wrHit(wrEn, idx, `ACS_IDX_OVR_CTRL)) begin
				ovrCtrl_r <= wb_dat_i[2:0];
			end
			if (wrHit(wrEn, idx, `ACS_IDX_OVR_LEN)) begin
				ovrLen_r <= wb_dat_i[7:0];
			end
		end
	end

	assign ovrClrPulse = wrHit(wrEn, idx, `ACS_IDX_OVR_CTRL)
		&& wb_dat_i[2:1] == `ACS_OVR_CLR_CODE;

	acs_ovr_stretch uStretch (
		.clk(clk),
		.rst(regRst),
		.ovrIn(ovrIn),
		.sticky(ovrCtrl_r[`ACS_BIT_OVR_STICKY]),
		.clrCode(ovrClrPulse),
		.len(ovrLen_r),
		.ovrOut(ovrStretched)
	);

	assign ovrOut = ovrStretched;

	//////////////////////////////////////////////////////////////////////
	// fuse load sequencer, restarted only by hardware reset
	acs_fuse_load uFuse (
		.clk(clk),
		.sys_rst(sys_rst),
		.ready(fuseReady)
	);

	assign cfgReady = fuseReady;

	//////////////////////////////////////////////////////////////////////
	// output link controls, channel swap defaults to normal order
	always_ff @(posedge clk) begin
		if (regRst) begin
			lvdsTerm_r <= LinkResetVal[`ACS_BIT_LVDS_TERM];
			halfSwing_r <= LinkResetVal[`ACS_BIT_HALF_SWING];
			chanSwap_r <= LinkResetVal[`ACS_BIT_CHAN_SWAP];
		end else if (wrHit(wrEn, idx, `ACS_IDX_LINK)) begin
			lvdsTerm_r <= wb_dat_i[`ACS_BIT_LVDS_TERM];
			halfSwing_r <= wb_dat_i[`ACS_BIT_HALF_SWING];
			chanSwap_r <= wb_dat_i[`ACS_BIT_CHAN_SWAP];
		end
	end

	// control outputs straight from flops
	always_ff @(posedge clk) begin
		if (regRst) begin
			termCtrl <= 2'h0;
			lvdsTerm <= 1'b0;
			lvdsHalfSwing <= 1'b0;
		end else begin
			termCtrl <= term_r;
			lvdsTerm <= lvdsTerm_r;
			lvdsHalfSwing <= halfSwing_r;
		end
	end

	// data path swap; one register stage either way keeps latency equal
	always_ff @(posedge clk) begin
		if (regRst) begin
			chAOut <= 16'h0000;
			chBOut <= 16'h0000;
		end else if (chanSwap_r) begin
			chAOut <= chAIn;
			chBOut <= chBIn;
		end else begin
			chAOut <= chBIn;
			chBOut <= chAIn;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// interrupt events: overrange rise, refsync detect, config ready rise
	always_ff @(posedge clk) begin
		if (regRst) begin
			ovrPrev_r <= 1'b0;
		end else begin
			ovrPrev_r <= ovrStretched;
		end
	end

	// follows the fuse sequencer's reset, else soft reset fakes a ready rise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfgPrev_r <= 1'b0;
		end else begin
			cfgPrev_r <= fuseReady;
		end
	end

	assign intSet[`ACS_INT_OVR] = ovrStretched && !ovrPrev_r;
	assign intSet[`ACS_INT_REFSYNC] = refsyncIn;
	assign intSet[`ACS_INT_CFG_RDY] = fuseReady && !cfgPrev_r;

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge clk) begin
		if (regRst) begin
			intStat_r <= 3'h0;
			intMask_r <= 3'h0;
		end else begin
			if (wrHit(wrEn, idx, `ACS_IDX_INT_STAT)) begin
				intStat_r <= (intStat_r & ~wb_dat_i[2:0]) | intSet;
			end else begin
				intStat_r <= intStat_r | intSet;
			end
			if (wrHit(wrEn, idx, `ACS_IDX_INT_MASK)) begin
				intMask_r <= wb_dat_i[2:0];
			end
		end
	end

	// level interrupt; one cycle behind the status bit
	always_ff @(posedge clk) begin
		if (regRst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(intStat_r & intMask_r);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read mux; unmapped indices read zero and still get ack
	always_comb begin
		rdData = `ACS_READ_UNMAPPED;
		case (idx)
			`ACS_IDX_CFG_RDY: rdData[`ACS_BIT_CFG_RDY] = fuseReady;
			`ACS_IDX_SW_RST: rdData[`ACS_BIT_SW_RST] = swRst_r;
			`ACS_IDX_GPD: rdData[`ACS_BIT_GPD] = gpd_r;
			`ACS_IDX_REFCLR: rdData[`ACS_BIT_REFCLR] = refClr_r;
			`ACS_IDX_TERM: rdData[1:0] = term_r;
			`ACS_IDX_OVR_CTRL: rdData[2:0] = ovrCtrl_r;
			`ACS_IDX_OVR_LEN: rdData[7:0] = ovrLen_r;
			`ACS_IDX_LINK: begin
				rdData[`ACS_BIT_LVDS_TERM] = lvdsTerm_r;
				rdData[`ACS_BIT_HALF_SWING] = halfSwing_r;
				rdData[`ACS_BIT_CHAN_SWAP] = chanSwap_r;
			end
			`ACS_IDX_STATUS: rdData[`ACS_BIT_REFFLAG] = refFlag_r;
			`ACS_IDX_GPIO_CFG: rdData[4:0] = gpioCfg_r;
			`ACS_IDX_INT_STAT: rdData[2:0] = intStat_r;
			`ACS_IDX_INT_MASK: rdData[2:0] = intMask_r;
			default: rdData = `ACS_READ_UNMAPPED;
		endcase
	end

	// read data is captured with ack and held until the next read is answered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_r;
			if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
				wb_dat_o <= rdData;
			end
		end
	end

endmodule
`default_nettype wire

// [shared/acs_map.svh]
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// register indices; byte address is four times the index
`define ACS_IDX_CFG_RDY 12'h025
`define ACS_IDX_SW_RST 12'h100
`define ACS_IDX_GPD 12'h101
`define ACS_IDX_REFCLR 12'h102
`define ACS_IDX_TERM 12'h104
`define ACS_IDX_OVR_CTRL 12'h10a
`define ACS_IDX_OVR_LEN 12'h10b
`define ACS_IDX_LINK 12'h110
`define ACS_IDX_STATUS 12'h140
`define ACS_IDX_GPIO_CFG 12'h146
`define ACS_IDX_INT_STAT 12'h180
`define ACS_IDX_INT_MASK 12'h181

// field positions
`define ACS_BIT_CFG_RDY 4
`define ACS_BIT_SW_RST 0
`define ACS_BIT_GPD 4
`define ACS_BIT_REFCLR 6
`define ACS_BIT_REFFLAG 6
`define ACS_BIT_OVR_STICKY 0
`define ACS_BIT_LVDS_TERM 7
`define ACS_BIT_HALF_SWING 5
`define ACS_BIT_CHAN_SWAP 1

// field values and reset values
`define ACS_OVR_CLR_CODE 2'h2
`define ACS_GPIO_PDN_CODE 5'h01
`define ACS_LINK_RESET 8'h02
`define ACS_OVR_LEN_RESET 8'h00
`define ACS_READ_UNMAPPED 32'h0000_0000

// interrupt status bit positions
`define ACS_INT_OVR 0
`define ACS_INT_REFSYNC 1
`define ACS_INT_CFG_RDY 2

// timing: fuse load time in ns, least time so rounded up
`define ACS_CLK_PERIOD_NS 5
`define ACS_FUSE_LOAD_NS 1000
`define ACS_FUSE_CYC ((`ACS_FUSE_LOAD_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// [shared/acs_pkg.sv]
package acs_pkg;
	typedef enum logic [0:0] {FUSE_LOADING, FUSE_DONE} acs_fuse_state_type;
endpackage

// [verif/acs_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_regs_properties (
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_ack_o, // acknowledge
	input wire logic ovrIn, // raw overrange
	input wire logic ovrOut, // overrange indication
	input wire logic [15:0] chAIn, // channel A in
	input wire logic [15:0] chBIn, // channel B in
	input wire logic [15:0] chAOut, // channel A out
	input wire logic [15:0] chBOut, // channel B out
	input wire logic powerDown, // global power down
	input wire logic cfgReady, // configuration ready
	input wire logic irq // interrupt
);
	logic [8:0] rstCnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////
	// cycles since hardware reset; soft reset must not restart it
	always_ff @(posedge clk) begin
		if (sys_rst) rstCnt_r <= 9'h000;
		else if (rstCnt_r != 9'h1ff) rstCnt_r <= rstCnt_r + 9'h001;
	end

	////////////////////////////////////////////////////////////////
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	// one cycle slack each side covers how the release edge is counted
	chk_cfg_early: assert property (rstCnt_r < `ACS_FUSE_CYC - 1 |-> !cfgReady)
		else $error("config ready before fuse load ends");
	chk_cfg_late: assert property (rstCnt_r > `ACS_FUSE_CYC |-> cfgReady)
		else $error("config ready missing after fuse load");
	chk_ovr_set: assert property (ovrIn |=> ovrOut)
		else $error("overrange event not indicated");
	chk_ovr_drop: assert property ($fell(ovrOut) |-> !$past(ovrIn))
		else $error("indication dropped right after an event");
	// soft reset may zero the outputs, so its cycle is left out
	chk_swap_pair: assert property (!$past(sys_rst) && !$past(wb_ack_o, 2) |->
		(chAOut == $past(chAIn) && chBOut == $past(chBIn)) ||
		(chAOut == $past(chBIn) && chBOut == $past(chAIn)))
		else $error("channel outputs not a copy of the inputs");
	chk_rst_quiet: assert property (disable iff (1'b0)
		sys_rst |=> !wb_ack_o && !powerDown && !cfgReady && !ovrOut && !irq)
		else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// [verif/acs_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_regs_tb_top;
	logic clk = 1'b0, sysRst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [13:0] wbAdr = 14'h0000;
	logic [3:0] wbSel = 4'h0, selV = 4'hf;
	logic [31:0] wbDat = 32'h0000_0000, wbDatO, rd;
	logic wbAck, ovrIn = 1'b0, refsyncIn = 1'b0, gpioPin = 1'b0;
	logic [15:0] chA = 16'h0000, chB = 16'h0000, chAOut, chBOut;
	logic ovrOut, powerDown, cfgReady, lvdsTerm, lvdsHalf, irq;
	logic [1:0] termCtrl;
	logic [7:0] r;
	int failCount = 0, totalChecks = 0, cycles = 0, seed = 77935, n, i;

	always #2.5 clk = ~clk;

	acs_regs i_dut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .ovrIn(ovrIn), .refsyncIn(refsyncIn),
		.gpioPin(gpioPin), .chAIn(chA), .chBIn(chB), .chAOut(chAOut), .chBOut(chBOut),
		.ovrOut(ovrOut), .powerDown(powerDown), .cfgReady(cfgReady), .termCtrl(termCtrl),
		.lvdsTerm(lvdsTerm), .lvdsHalfSwing(lvdsHalf), .irq(irq));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task closeOut;
		if (failCount == 0 && totalChecks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// hang guard, the whole run needs under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failCount++;
			closeOut;
		end
	end

	function automatic logic [15:0] expA(input logic sw, input logic [15:0] a, input logic [15:0] b);
		return sw ? a : b;
	endfunction

	// classic cycle: hold until ack is sampled, then one idle cycle
	task automatic xfer(input logic we, input logic [11:0] idx, input logic [7:0] d);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbSel <= selV;
		wbDat <= {24'h00_0000, d};
		// no local limit: only the hang guard ends a wait for ack
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge clk);
	endtask

	task pulseOvr;
		ovrIn <= 1'b1;
		@(posedge clk);
		ovrIn <= 1'b0;
	endtask

	task pulseRef;
		refsyncIn <= 1'b1;
		@(posedge clk);
		refsyncIn <= 1'b0;
	endtask

	// events one idle cycle apart, then count how long the indication stands
	task automatic stretch(input int reps, output int cnt);
		cnt = 0;
		repeat (reps) begin
			pulseOvr;
			@(posedge clk);
		end
		while (ovrOut === 1'b1 && cnt < 300) begin
			cnt++;
			@(posedge clk);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		xfer(1'b0, `ACS_IDX_CFG_RDY, 8'h00);
		check(rd, 32'h0000_0000);
		xfer(1'b0, `ACS_IDX_LINK, 8'h00);
		check(rd, 32'h0000_0002);
		xfer(1'b1, 12'h3ff, 8'hff);
		xfer(1'b0, 12'h3ff, 8'h00);
		check(rd, 32'h0000_0000);
		n = 0;
		while (cfgReady !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		xfer(1'b0, `ACS_IDX_CFG_RDY, 8'h00);
		check(rd, 32'h0000_0010);
		// normal order first, then exchanged with both lvds bits set
		for (i = 0; i < 2; i++) begin
			chA <= 16'($random(seed));
			chB <= 16'($random(seed));
			repeat (3) @(posedge clk);
			check(chAOut, expA(i == 0, chA, chB));
			check(chBOut, expA(i == 0, chB, chA));
			xfer(1'b1, `ACS_IDX_LINK, 8'ha0);
		end
		check({lvdsTerm, lvdsHalf}, 2'h3);
		selV = 4'he;
		xfer(1'b1, `ACS_IDX_LINK, 8'h02);
		selV = 4'hf;
		xfer(1'b0, `ACS_IDX_LINK, 8'h00);
		check(rd, 32'h0000_00a0);
		r = 8'($random(seed)) & 8'h03;
		xfer(1'b1, `ACS_IDX_TERM, r);
		xfer(1'b0, `ACS_IDX_TERM, 8'h00);
		check(rd, {24'h00_0000, r});
		check(termCtrl, r[1:0]);
		// register bit, then pin with the power-down code and with another
		xfer(1'b1, `ACS_IDX_GPD, 8'h10);
		repeat (3) @(posedge clk);
		check(powerDown, 1'b1);
		xfer(1'b1, `ACS_IDX_GPD, 8'h00);
		repeat (3) @(posedge clk);
		check(powerDown, 1'b0);
		for (i = 1; i < 3; i++) begin
			xfer(1'b1, `ACS_IDX_GPIO_CFG, 8'(i));
			gpioPin <= 1'b1;
			repeat (3) @(posedge clk);
			check(powerDown, i == 1);
			gpioPin <= 1'b0;
		end
		// zero, mid and full lengths; odd passes restart during the pulse
		for (i = 0; i < 4; i++) begin
			r = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'h02 + (8'($random(seed)) & 8'h07);
			xfer(1'b1, `ACS_IDX_OVR_LEN, r);
			stretch(i % 2 + 1, n);
			check(n, r + 32'h0000_0001);
		end
		xfer(1'b1, `ACS_IDX_OVR_LEN, 8'h00);
		xfer(1'b1, `ACS_IDX_OVR_CTRL, 8'h01);
		pulseOvr;
		repeat (20) @(posedge clk);
		check(ovrOut, 1'b1);
		xfer(1'b1, `ACS_IDX_OVR_CTRL, 8'h03);
		repeat (3) @(posedge clk);
		check(ovrOut, 1'b1);
		xfer(1'b1, `ACS_IDX_OVR_CTRL, 8'h05);
		repeat (3) @(posedge clk);
		check(ovrOut, 1'b0);
		pulseRef;
		xfer(1'b0, `ACS_IDX_STATUS, 8'h00);
		check(rd, 32'h0000_0040);
		xfer(1'b1, `ACS_IDX_REFCLR, 8'h40);
		xfer(1'b1, `ACS_IDX_REFCLR, 8'h00);
		xfer(1'b0, `ACS_IDX_STATUS, 8'h00);
		check(rd, 32'h0000_0000);
		// interrupt: masked in, cleared by write one, masked out
		xfer(1'b0, `ACS_IDX_INT_STAT, 8'h00);
		check(rd, 32'h0000_0007);
		xfer(1'b1, `ACS_IDX_INT_MASK, 8'h02);
		repeat (3) @(posedge clk);
		check(irq, 1'b1);
		xfer(1'b1, `ACS_IDX_INT_STAT, 8'h07);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		pulseRef;
		repeat (3) @(posedge clk);
		check(irq, 1'b1);
		xfer(1'b1, `ACS_IDX_INT_MASK, 8'h00);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		// soft reset restores defaults but keeps the fuse result
		xfer(1'b1, `ACS_IDX_GPD, 8'h10);
		xfer(1'b1, `ACS_IDX_SW_RST, 8'h01);
		repeat (3) @(posedge clk);
		check({powerDown, cfgReady}, 2'h1);
		xfer(1'b0, `ACS_IDX_SW_RST, 8'h00);
		check(rd, 32'h0000_0000);
		xfer(1'b0, `ACS_IDX_LINK, 8'h00);
		check(rd, 32'h0000_0002);
		xfer(1'b0, `ACS_IDX_OVR_CTRL, 8'h00);
		check(rd, 32'h0000_0000);
		xfer(1'b0, `ACS_IDX_INT_STAT, 8'h00);
		check(rd, 32'h0000_0000);
		closeOut;
	end
endmodule

bind acs_regs acs_regs_properties i_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ovrIn(ovrIn), .ovrOut(ovrOut),
	.chAIn(chAIn), .chBIn(chBIn), .chAOut(chAOut), .chBOut(chBOut),
	.powerDown(powerDown), .cfgReady(cfgReady), .irq(irq));
`default_nettype wire
